// ### rtl/bmsi_top.v
`timescale 1ns/100ps
`include "bmsi_map.vh"
module bmsi_top #(
  parameter TICK_CYC = `BMSI_TICK_NS / `BMSI_CLK_NS,
  parameter PULSE_TICKS = `BMSI_PULSE_MS / 100
) (
  input wire sys_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [2:0] fb_closed,
  input wire [2:0] fb_opened,
  input wire spring_gen_tie,
  input wire spring_mains,
  input wire restart_req,
  input wire [15:0] peer_section_block,
  output reg [2:0] brk_close_ff,
  output reg [2:0] brk_open_ff,
  output reg [15:0] section_block_ff,
  output reg pos_fail_notify_ff,
  output reg [13:0] relay_ff,
  output reg limits_ff,
  output reg [8:0] class_act_ff,
  output reg trip_gen_ff,
  output reg trip_mains_ff
);
  // ****************************************************
  // pin synchronisers: first stage feeds only the second
  // ****************************************************
  reg [8:0] s1_ff;
  reg [8:0] s2_ff;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 9'h000;
      s2_ff <= 9'h000;
    end else begin
      s1_ff <= {restart_req, spring_mains, spring_gen_tie, fb_opened,
                fb_closed};
      s2_ff <= s1_ff;
    end
  end
  wire [2:0] cl = s2_ff[2:0];
  wire [2:0] op = s2_ff[5:3];
  wire [2:0] spr_in = {s2_ff[6], s2_ff[7], s2_ff[6]};
  wire rst_req = s2_ff[8];
  // peer block requests come from other controllers, so they sync too
  reg [15:0] peer_s1_ff;
  reg [15:0] peer_s2_ff;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      peer_s1_ff <= 16'h0000;
      peer_s2_ff <= 16'h0000;
    end else begin
      peer_s1_ff <= peer_section_block;
      peer_s2_ff <= peer_s1_ff;
    end
  end

  // ****************************************************
  // tenth-of-second timebase
  // ****************************************************
  reg [31:0] tb_cnt_ff;
  reg tick_ff;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tb_cnt_ff <= 32'h0;
      tick_ff <= 1'b0;
    end else if (tb_cnt_ff >= TICK_CYC - 1) begin
      tb_cnt_ff <= 32'h0;
      tick_ff <= 1'b1;
    end else begin
      tb_cnt_ff <= tb_cnt_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

  // ****************************************************
  // registers
  // ****************************************************
  reg [31:0] mof_ff, mcf_ff, gpf_ff, mpf_ff, spr_ff, tie_ff;
  reg [2:0] close_req_ff, open_req_ff;
  wire wr = psel & penable & pwrite;
  assign pready = 1'b1; // every access ends in one access cycle
  assign pslverr = 1'b0;

  // clamp a timer field into its range so a bad write stays sane
  function [31:0] clamp_cfg;
    input [31:0] v;
    input [6:0] tmax;
    reg [6:0] t;
    begin
      t = v[`BMSI_F_TMR_HI:`BMSI_F_TMR_LO];
      if (t < `BMSI_TMR_MIN) t = `BMSI_TMR_MIN;
      if (t > tmax) t = tmax;
      clamp_cfg = {8'h00, v[23:8], 1'b0, t};
    end
  endfunction

  function [31:0] clamp_load;
    input [31:0] v;
    begin
      clamp_load = v;
      if (v[8:0] > `BMSI_LOAD_MAX) clamp_load[8:0] = `BMSI_LOAD_MAX;
      if (v[24:16] > `BMSI_LOAD_MAX) clamp_load[24:16] = `BMSI_LOAD_MAX;
    end
  endfunction

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mof_ff <= `BMSI_RV_SUP;
      mcf_ff <= `BMSI_RV_SUP;
      gpf_ff <= `BMSI_RV_POS;
      mpf_ff <= `BMSI_RV_POS;
      spr_ff <= `BMSI_RV_SPR;
      tie_ff <= `BMSI_RV_TIE;
      close_req_ff <= 3'h0;
      open_req_ff <= 3'h0;
    end else begin
      close_req_ff <= 3'h0;
      open_req_ff <= 3'h0;
      if (wr) begin
        case (paddr)
          `BMSI_A_MOF_CFG: mof_ff <= clamp_cfg(pwdata, `BMSI_SUP_MAX);
          `BMSI_A_MCF_CFG: mcf_ff <= clamp_cfg(pwdata, `BMSI_SUP_MAX);
          `BMSI_A_GPF_CFG: gpf_ff <= clamp_cfg(pwdata, `BMSI_POS_MAX);
          `BMSI_A_MPF_CFG: mpf_ff <= clamp_cfg(pwdata, `BMSI_POS_MAX);
          `BMSI_A_SPR_CFG: spr_ff <= clamp_load(pwdata);
          `BMSI_A_TIE_CFG: begin
            tie_ff[8:0] <= (pwdata[8:0] > `BMSI_LOAD_MAX) ?
              `BMSI_LOAD_MAX : pwdata[8:0];
            tie_ff[31:16] <= (pwdata[31:16] > 16'h4e20) ?
              16'h4e20 : pwdata[31:16]; // open point kW
          end
          `BMSI_A_CMD: begin
            close_req_ff <= pwdata[2:0];
            open_req_ff <= pwdata[10:8];
          end
          default: ;
        endcase
      end
    end
  end
  // spr_ff: [8:0] gen load, [24:16] mains load, [25] timer mode,
  // [26] input mode, [28:27] mains type, [30:29] gen/tie type
  wire tmr_mode = spr_ff[25];
  wire inp_mode = spr_ff[26];
  wire [1:0] typ_m = spr_ff[28:27];
  wire [1:0] typ_g = spr_ff[30:29];
  wire [26:0] load_t = {tie_ff[8:0], spr_ff[24:16], spr_ff[8:0]};

  // ****************************************************
  // spring interlock per breaker (0 gen, 1 mains, 2 tie)
  // ****************************************************
  reg [8:0] rem_ff [0:2];
  reg [2:0] prev_op_ff, wait_spr_ff, pend_ff;
  wire [2:0] released;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : spr
      // both conditions must hold when both modes are set
      assign released[g] = (!tmr_mode || rem_ff[g] == 9'h0) &&
                           (!inp_mode || !wait_spr_ff[g] ||
                            spr_in[g]);
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          rem_ff[g] <= 9'h0;
          prev_op_ff[g] <= 1'b0;
          wait_spr_ff[g] <= 1'b0;
        end else begin
          prev_op_ff[g] <= op[g];
          if (op[g] && !prev_op_ff[g]) begin
            rem_ff[g] <= load_t[g*9 +: 9];
            wait_spr_ff[g] <= 1'b1;
          end else begin
            if (tick_ff && rem_ff[g] != 9'h0)
              rem_ff[g] <= rem_ff[g] - 9'h1;
            if (spr_in[g])
              wait_spr_ff[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************************
  // close/open command drive with pending restart
  // ****************************************************
  reg [9:0] cmd_cnt_ff [0:2];
  reg [2:0] cmd_is_close_ff;
  wire [6:0] sup_c = mcf_ff[6:0];
  wire [6:0] sup_o = mof_ff[6:0];
  generate
    for (g = 0; g < 3; g = g + 1) begin : drv
      wire [1:0] typ = (g == 1) ? typ_m : typ_g;
      wire want_close = close_req_ff[g] || (g == 0 && rst_req) ||
                        pend_ff[g];
      // continuous: hold for the supervision time pulse: short
      wire [9:0] len_c = (typ == `BMSI_BT_CONT) ? {3'h0, sup_c} :
                         PULSE_TICKS[9:0];
      wire [9:0] len_o = (typ == `BMSI_BT_CONT) ? {3'h0, sup_o} :
                         PULSE_TICKS[9:0];
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          cmd_cnt_ff[g] <= 10'h0;
          cmd_is_close_ff[g] <= 1'b0;
          pend_ff[g] <= 1'b0;
          brk_close_ff[g] <= 1'b0;
          brk_open_ff[g] <= 1'b0;
        end else begin
          if (open_req_ff[g]) begin
            pend_ff[g] <= 1'b0;
            cmd_cnt_ff[g] <= len_o;
            cmd_is_close_ff[g] <= 1'b0;
          end else if (want_close && cmd_cnt_ff[g] == 10'h0) begin
            if (released[g] && !section_block_ff[g]) begin
              pend_ff[g] <= 1'b0;
              cmd_cnt_ff[g] <= len_c;
              cmd_is_close_ff[g] <= 1'b1;
            end else
              pend_ff[g] <= 1'b1; // wait for interlock
          end else if (tick_ff && cmd_cnt_ff[g] != 10'h0)
            cmd_cnt_ff[g] <= cmd_cnt_ff[g] - 10'h1;
          brk_close_ff[g] <= cmd_cnt_ff[g] != 10'h0 && cmd_is_close_ff[g];
          brk_open_ff[g] <= cmd_cnt_ff[g] != 10'h0 && !cmd_is_close_ff[g];
        end
      end
    end
  endgenerate

  // ****************************************************
  // supervision: 0 mains open, 1 mains close, 2 gen pos, 3 mains pos
  // ****************************************************
  reg [6:0] sup_cnt_ff [0:3];
  reg [3:0] alarm_ff;
  reg [1:0] mon_ff;  // mains open/close supervision armed
  wire [3:0] en = {mpf_ff[16], gpf_ff[16], mcf_ff[16], mof_ff[16]};
  wire [3:0] cond;
  assign cond[0] = mon_ff[0] && !op[1];
  assign cond[1] = mon_ff[1] && !cl[1];
  assign cond[2] = ~(cl[0] ^ op[0]); // none or both
  assign cond[3] = ~(cl[1] ^ op[1]);
  wire [27:0] tmr = {mpf_ff[6:0], gpf_ff[6:0], mcf_ff[6:0], mof_ff[6:0]};
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      mon_ff <= 2'h0;
    else begin
      if (open_req_ff[1]) mon_ff <= 2'h1;
      else if (brk_close_ff[1] && cmd_cnt_ff[1] != 10'h0) mon_ff <= 2'h2;
      else if (alarm_ff[0] || op[1]) mon_ff[0] <= 1'b0;
      if (alarm_ff[1] || cl[1]) mon_ff[1] <= 1'b0;
    end
  end
  generate
    for (g = 0; g < 4; g = g + 1) begin : sup
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          sup_cnt_ff[g] <= 7'h0;
          alarm_ff[g] <= 1'b0;
        end else if (!en[g] || !cond[g]) begin
          sup_cnt_ff[g] <= 7'h0;
          alarm_ff[g] <= 1'b0; // disabled never alarms
        end else if (tick_ff) begin
          if (sup_cnt_ff[g] + 7'h1 >= tmr[g*7 +: 7])
            alarm_ff[g] <= 1'b1; // expiry
          else
            sup_cnt_ff[g] <= sup_cnt_ff[g] + 7'h1;
        end
      end
    end
  endgenerate

  // ****************************************************
  // alarm routing and fail class reaction
  // ****************************************************
  reg [13:0] nxt_relay;
  reg nxt_lim;
  reg [8:0] nxt_cls;
  reg [3:0] sa, sb;
  reg [31:0] c;
  integer i;
  always @* begin
    nxt_relay = 14'h0;
    nxt_lim = 1'b0;
    nxt_cls = 9'h0;
    sa = 4'h0;
    sb = 4'h0;
    c = 32'h0;
    for (i = 0; i < 4; i = i + 1) begin
      c = (i == 0) ? mof_ff : (i == 1) ? mcf_ff : (i == 2) ? gpf_ff : mpf_ff;
      sa = c[`BMSI_F_OA_HI:`BMSI_F_OA_LO];
      sb = c[`BMSI_F_OB_HI:`BMSI_F_OB_LO];
      if (alarm_ff[i] && en[i]) begin
        // codes above the limits code select nothing
        if (sa != `BMSI_SEL_NONE && sa <= `BMSI_SEL_LIM)
          nxt_relay[sa] = 1'b1;
        if (sb != `BMSI_SEL_NONE && sb <= `BMSI_SEL_LIM)
          nxt_relay[sb] = 1'b1;
        if (c[`BMSI_F_FC_HI:`BMSI_F_FC_LO] <= `BMSI_FC_CSTOP)
          nxt_cls[c[`BMSI_F_FC_HI:`BMSI_F_FC_LO]] = 1'b1;
      end
    end
    nxt_lim = nxt_relay[13];
  end
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      relay_ff <= 14'h0;
      limits_ff <= 1'b0;
      class_act_ff <= 9'h0;
      trip_gen_ff <= 1'b0;
      trip_mains_ff <= 1'b0;
      pos_fail_notify_ff <= 1'b0;
      section_block_ff <= 16'h0;
    end else begin
      relay_ff <= {1'b0, nxt_relay[12:0]};
      limits_ff <= nxt_lim;
      class_act_ff <= nxt_cls;
      trip_gen_ff <= nxt_cls[2] | nxt_cls[3] | nxt_cls[4] | nxt_cls[7];
      trip_mains_ff <= nxt_cls[5] | nxt_cls[7];
      pos_fail_notify_ff <= alarm_ff[2] | alarm_ff[3];
      // only sections flagged here or by peers are blocked
      section_block_ff <= peer_s2_ff |
                          {14'h0, alarm_ff[3], alarm_ff[2]};
    end
  end

  // ****************************************************
  // read mux; unmapped addresses read zero
  // ****************************************************
  always @* begin
    case (paddr)
      `BMSI_A_MOF_CFG: prdata = mof_ff;
      `BMSI_A_MCF_CFG: prdata = mcf_ff;
      `BMSI_A_GPF_CFG: prdata = gpf_ff;
      `BMSI_A_MPF_CFG: prdata = mpf_ff;
      `BMSI_A_SPR_CFG: prdata = spr_ff;
      `BMSI_A_TIE_CFG: prdata = tie_ff;
      `BMSI_A_STAT: prdata = {13'h0, released, pend_ff, s2_ff[8:0],
                              alarm_ff};
      `BMSI_A_REM01: prdata = {7'h0, rem_ff[1], 7'h0, rem_ff[0]};
      `BMSI_A_REM2: prdata = {23'h0, rem_ff[2]};
      default: prdata = 32'h0;
    endcase
  end
endmodule // bmsi_top

// ### pkg/bmsi_map.vh
// Operation
// - mains open-fail timer 1.0-10.0 s, default 2.0
// - mains close-fail timer 1.0-10.0 s, enable on
// - two output selections per alarm, default unused
// - continuous breakers: command held for timer
// - position fail when none or both feedbacks
// - notify peer controllers of position failure
// - only the affected section is blocked
// - position-fail delay 1.0-5.0 s, default 1.0
// - fail class decides reaction, may trip
// - timer mode blocks reclose until load time
// - input mode blocks reclose until spring input
// - two spring inputs: gen/tie, mains
// - both modes configured need both conditions
// - remaining spring time shown while counting
// - tie load time and open point settings
// - restart after open waits for interlock
// - pulse breakers get short close/open pulse
`ifndef BMSI_MAP_VH
`define BMSI_MAP_VH
// ****************************************************
// register offsets (byte addresses)
// ****************************************************
`define BMSI_A_MOF_CFG 12'h000
`define BMSI_A_MCF_CFG 12'h004
`define BMSI_A_GPF_CFG 12'h008
`define BMSI_A_MPF_CFG 12'h00c
`define BMSI_A_SPR_CFG 12'h010
`define BMSI_A_TIE_CFG 12'h014
`define BMSI_A_CMD 12'h018
`define BMSI_A_STAT 12'h01c
`define BMSI_A_REM01 12'h020
`define BMSI_A_REM2 12'h024
// ****************************************************
// supervision config fields: timer, outputs, enable, class
// ****************************************************
`define BMSI_F_TMR_LO 0
`define BMSI_F_TMR_HI 6
`define BMSI_F_OA_LO 8
`define BMSI_F_OA_HI 11
`define BMSI_F_OB_LO 12
`define BMSI_F_OB_HI 15
`define BMSI_F_EN 16
`define BMSI_F_FC_LO 20
`define BMSI_F_FC_HI 23
// ****************************************************
// reset values; timers in tenths of a second
// ****************************************************
`define BMSI_RV_SUP 32'h0011_0014
`define BMSI_RV_POS 32'h0011_000a
`define BMSI_RV_SPR 32'h0000_0000
`define BMSI_RV_TIE 32'h0032_0000
`define BMSI_TMR_MIN 7'h0a
`define BMSI_SUP_MAX 7'h64
`define BMSI_POS_MAX 7'h32
`define BMSI_LOAD_MAX 9'h12c
// output select: 0 unused, 1..12 relays, 13 limits
`define BMSI_SEL_NONE 4'h0
`define BMSI_SEL_LIM 4'hd
// fail classes
`define BMSI_FC_BLOCK 4'h0
`define BMSI_FC_WARN 4'h1
`define BMSI_FC_TRIPG 4'h2
`define BMSI_FC_TRSTOP 4'h3
`define BMSI_FC_SHUT 4'h4
`define BMSI_FC_TRIPM 4'h5
`define BMSI_FC_SAFE 4'h6
`define BMSI_FC_TRIPGM 4'h7
`define BMSI_FC_CSTOP 4'h8
// breaker types
`define BMSI_BT_CONT 2'h0
`define BMSI_BT_PULSE 2'h1
// timebase and pulse
`define BMSI_TICK_NS 100000000
`define BMSI_CLK_NS 20
`define BMSI_PULSE_MS 200
`endif

// ### tb/bmsi_asserts.sv
`timescale 1ns/100ps
// ****************************
// port checks, breaker monitor
// ****************************
module bmsi_asserts #(
  parameter TICK_CYC = 10
) (
  input wire sys_clk,
  input wire nrst,
  input wire pready,
  input wire pslverr,
  input wire [2:0] fb_closed,
  input wire [2:0] fb_opened,
  input wire [15:0] peer_section_block,
  input wire [15:0] section_block_ff,
  input wire pos_fail_notify_ff,
  input wire [13:0] relay_ff,
  input wire [8:0] class_act_ff,
  input wire trip_gen_ff,
  input wire trip_mains_ff,
  input wire [2:0] brk_close_ff
);
  reg [31:0] bad_cnt_ff;
  wire [1:0] bad_now = ~(fb_closed[1:0] ^ fb_opened[1:0]);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // raw bad cycles; the synchroniser only adds to them
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) bad_cnt_ff <= 32'h0;
    else if (bad_now == 2'h0) bad_cnt_ff <= 32'h0;
    else bad_cnt_ff <= bad_cnt_ff + 32'h1;
  end
  a_reset_clear: assert property ($rose(nrst) |->
    ({brk_close_ff, relay_ff, pos_fail_notify_ff} == 18'h0))
    else $error("outputs not clear after reset");
  a_zero_wait: assert property (pready && !pslverr)
    else $error("slave stalled or flagged an error");
  a_spare_relay: assert property (!relay_ff[0] && !relay_ff[13])
    else $error("relay bit without a selection code");
  a_peer_only: assert property (
    $stable(peer_section_block) [*6] |->
    section_block_ff[15:2] == peer_section_block[15:2])
    else $error("section block differs from peer request");
  a_good_quiet: assert property (
    $stable({fb_closed, fb_opened}) [*6] ##0 (bad_now == 2'h0)
    |-> !pos_fail_notify_ff)
    else $error("position fail with sound feedback");
  a_fail_delay: assert property (
    $rose(pos_fail_notify_ff) |-> bad_cnt_ff >= 9 * TICK_CYC)
    else $error("position fail before its delay");
  a_fail_block: assert property (
    $rose(pos_fail_notify_ff) |-> ##[0:2] section_block_ff[1:0] != 2'h0)
    else $error("position fail left its section open");
  a_trip_gen: assert property (
    $rose(class_act_ff[2]) |-> ##[0:2] trip_gen_ff)
    else $error("generator trip class without trip");
  a_trip_mains: assert property (
    $rose(class_act_ff[5]) |-> ##[0:2] trip_mains_ff)
    else $error("mains trip class without trip");
endmodule // bmsi_asserts
bind bmsi_top bmsi_asserts #(.TICK_CYC(TICK_CYC)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .pready(pready), .pslverr(pslverr),
  .fb_closed(fb_closed), .fb_opened(fb_opened),
  .peer_section_block(peer_section_block),
  .section_block_ff(section_block_ff),
  .pos_fail_notify_ff(pos_fail_notify_ff), .relay_ff(relay_ff),
  .class_act_ff(class_act_ff), .trip_gen_ff(trip_gen_ff),
  .trip_mains_ff(trip_mains_ff), .brk_close_ff(brk_close_ff));

// ### tb/bmsi_brk_model.sv
`timescale 1ns/100ps
// ****************************
// breakers with spring contacts
// ****************************
module bmsi_brk_model (
  input wire sys_clk,
  input wire [2:0] cmd_close,
  input wire [2:0] cmd_open,
  input wire [2:0] stuck,
  input wire [2:0] bad,
  output wire [2:0] fb_closed,
  output wire [2:0] fb_opened,
  output wire spring_gen_tie,
  output wire spring_mains
);
  reg [2:0] pos_ff = 3'h0;
  reg [6:0] sgt_ff = 7'h0;
  reg [6:0] smn_ff = 7'h0;
  wire [2:0] go = ~stuck;
  wire [2:0] opening = pos_ff & cmd_open & go;
  // a jammed breaker ignores commands; springs recharge in 60 cycles
  always @(posedge sys_clk) begin
    pos_ff <= (pos_ff | (cmd_close & go)) & ~(cmd_open & go);
    if (opening[0] || opening[2]) sgt_ff <= 7'h3c;
    else if (sgt_ff != 7'h0) sgt_ff <= sgt_ff - 7'h1;
    if (opening[1]) smn_ff <= 7'h3c;
    else if (smn_ff != 7'h0) smn_ff <= smn_ff - 7'h1;
  end
  // a broken contact pair reads both positions at once
  assign fb_closed = pos_ff | bad;
  assign fb_opened = ~pos_ff | bad;
  assign spring_gen_tie = (sgt_ff == 7'h0);
  assign spring_mains = (smn_ff == 7'h0);
endmodule // bmsi_brk_model

// ### tb/breaker_monitor_spring_interlock_tb.sv
`timescale 1ns/100ps
`include "bmsi_map.vh"
// ****************************
// bench: apb calls, breaker model
// ****************************
module breaker_monitor_spring_interlock_tb;
  localparam TCK = 10;
  reg sys_clk = 1'b0;
  reg nrst = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg restart_req = 1'b0;
  reg [15:0] peer = 16'h0;
  reg [2:0] stuck = 3'h0;
  reg [2:0] bad = 3'h0;
  reg [31:0] q;
  wire [31:0] prdata;
  wire pready, sgt, smn, notify, trip_g, trip_m, lim;
  wire [2:0] fb_c, fb_o, cls, opn;
  wire [15:0] blk;
  wire [13:0] relay;
  wire [8:0] cls_act;
  wire [9:0] ev = {pready, ~notify, ~relay[3], ~cls[1], cls[1], relay[3],
    notify, cls[0], fb_o[0], fb_c[0]};
  integer failures = 0;
  integer num_checks = 0;
  integer n;
  bmsi_top #(.TICK_CYC(TCK)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .fb_closed(fb_c), .fb_opened(fb_o),
    .spring_gen_tie(sgt), .spring_mains(smn), .restart_req(restart_req),
    .peer_section_block(peer), .brk_close_ff(cls), .brk_open_ff(opn),
    .section_block_ff(blk), .pos_fail_notify_ff(notify), .relay_ff(relay),
    .limits_ff(lim), .class_act_ff(cls_act), .trip_gen_ff(trip_g),
    .trip_mains_ff(trip_m));
  bmsi_brk_model brk (
    .sys_clk(sys_clk), .cmd_close(cls), .cmd_open(opn), .stuck(stuck),
    .bad(bad), .fb_closed(fb_c), .fb_opened(fb_o), .spring_gen_tie(sgt),
    .spring_mains(smn));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task end_of_test;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  task chk_word(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // bounded wait on one event bit; running out ends the run
  task wait_on(input integer s, input integer lim);
    begin
      n = 0;
      while (ev[s] !== 1'b1 && n < lim) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      if (n == lim) begin
        failures = failures + 1;
        $display("ERROR %0t wait %0d ran out", $time, s);
        end_of_test;
      end
    end
  endtask
  // setup, access, held until pready at a rising edge
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      wait_on(9, 20);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk_word(q, e);
    end
  endtask
  // close, open, then ask for a restart close at once
  task lock(input [31:0] cfg, input rem, input integer lo, input integer hi);
    begin
      apb(1'b1, `BMSI_A_SPR_CFG, cfg);
      apb(1'b1, `BMSI_A_CMD, 32'h1);
      wait_on(0, 100);
      repeat (3 * TCK) @(posedge sys_clk);
      apb(1'b1, `BMSI_A_CMD, 32'h100);
      wait_on(1, 100);
      restart_req <= 1'b1;
      apb(1'b0, `BMSI_A_REM01, 32'h0);
      chk_word({31'h0, q[8:0] != 9'h0}, {31'h0, rem});
      wait_on(2, 400);
      chk_word({31'h0, n >= lo && n <= hi}, 32'h1);
      restart_req <= 1'b0;
      wait_on(0, 100);
      repeat (3 * TCK) @(posedge sys_clk);
    end
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`BMSI_A_MOF_CFG, `BMSI_RV_SUP);
    rd(`BMSI_A_MCF_CFG, `BMSI_RV_SUP);
    rd(`BMSI_A_GPF_CFG, `BMSI_RV_POS);
    rd(`BMSI_A_MPF_CFG, `BMSI_RV_POS);
    rd(`BMSI_A_SPR_CFG, `BMSI_RV_SPR);
    rd(`BMSI_A_TIE_CFG, `BMSI_RV_TIE);
    apb(1'b1, 12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0);
    // timers clamp at both ends of their range
    apb(1'b1, `BMSI_A_MOF_CFG, 32'h0051_d37f);
    rd(`BMSI_A_MOF_CFG, 32'h0051_d364);
    apb(1'b1, `BMSI_A_MCF_CFG, 32'h0);
    rd(`BMSI_A_MCF_CFG, 32'h0000_000a);
    apb(1'b1, `BMSI_A_GPF_CFG, 32'h0021_047f);
    rd(`BMSI_A_GPF_CFG, 32'h0021_0432);
    lock(32'h2a00_0014, 1'b1, 170, 260);
    lock(32'h2c00_0000, 1'b0, 50, 100);
    lock(32'h2e00_0002, 1'b1, 50, 100);
    // jammed mains breaker: close fail, then disabled
    stuck <= 3'h2;
    apb(1'b1, `BMSI_A_MCF_CFG, 32'h0051_d30a);
    apb(1'b1, `BMSI_A_CMD, 32'h2);
    wait_on(5, 20);
    wait_on(6, 100);
    // a pulse lasts two timebase ticks, the first one partial
    chk_word({31'h0, n > TCK && n <= 2 * TCK}, 32'h1);
    wait_on(4, 300);
    chk_word({31'h0, n >= 60 && n <= 110}, 32'h1);
    chk_word({29'h0, lim, cls_act[5], trip_m}, 32'h7);
    apb(1'b1, `BMSI_A_MCF_CFG, 32'h0050_d30a);
    wait_on(7, 20);
    apb(1'b1, `BMSI_A_CMD, 32'h2);
    repeat (15 * TCK) @(posedge sys_clk);
    chk_word({29'h0, lim, relay[3], cls_act[5]}, 32'h0);
    stuck <= 3'h0;
    // continuous mains breaker: close held for the 1.0 s timer
    apb(1'b1, `BMSI_A_SPR_CFG, 32'h2000_0000);
    apb(1'b1, `BMSI_A_CMD, 32'h2);
    wait_on(5, 20);
    wait_on(6, 200);
    chk_word({31'h0, n > 9 * TCK && n <= 10 * TCK}, 32'h1);
    // broken generator contacts beside a peer block
    peer <= 16'h0010;
    bad <= 3'h1;
    wait_on(3, 700);
    chk_word({31'h0, n >= 480 && n <= 560}, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk_word({16'h0, blk}, 32'h0000_0011);
    chk_word({18'h0, relay}, 32'h0000_0010);
    chk_word({31'h0, trip_g}, 32'h1);
    bad <= 3'h0;
    peer <= 16'h0;
    wait_on(8, 20);
    end_of_test;
  end
endmodule // breaker_monitor_spring_interlock_tb
